// ---- verilog/pci_phy_config_interface.v ----
`timescale 1ns/100ps
`include "pci_regs.vh"

module pci_phy_config_interface #(
  parameter PWRUP_CYCLES = `PCI_PWRUP_CYCLES
) (
  input wire i_sys_clk,
  input wire i_nrst,
  // AXI4-Lite slave.
  input wire [4:0] i_s_axi_awaddr,
  input wire [2:0] i_s_axi_awprot,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [4:0] i_s_axi_araddr,
  input wire [2:0] i_s_axi_arprot,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Chip-level status.
  input wire i_standby,
  input wire i_analog_power_detect,
  // PHY strap and reset outputs.
  output reg o_phy_soft_reset_n,
  output reg o_phy_clock_select,
  output reg [2:0] o_phy_start_mode,
  output reg [15:0] o_id_word1_init,
  output reg [15:0] o_id_word2_init,
  output reg [4:0] o_mgmt_address_init,
  output reg o_phy_autoneg_enable,
  output reg o_phy_speed_100,
  output reg o_phy_full_duplex,
  output reg o_phy_power_down,
  output reg o_phy_crs_on_transmit
);

  // ========================================================================
  // Helper functions

  // Merges the two low byte lanes of a write into a 16-bit register.
  function [15:0] merge_lanes;
    input [15:0] old_value;
    input [31:0] wdata;
    input [3:0] wstrb;
    begin
      merge_lanes = old_value;
      if (wstrb[0]) begin
        merge_lanes[7:0] = wdata[7:0];
      end
      if (wstrb[1]) begin
        merge_lanes[15:8] = wdata[15:8];
      end
    end
  endfunction

  // True when the address hits one of the five registers.
  function addr_mapped;
    input [4:0] addr;
    begin
      case (addr)
        `PCI_ADDR_MODE_CTRL,
        `PCI_ADDR_ID_WORD1,
        `PCI_ADDR_ID_WORD2,
        `PCI_ADDR_MGMT_ADDR,
        `PCI_ADDR_PWR_STATUS: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // True for the modes in which carrier sense also covers transmit.
  function mode_crs_tx;
    input [2:0] mode;
    begin
      mode_crs_tx = (mode == `PCI_MODE_100_HALF) || (mode == `PCI_MODE_AN_100_HALF);
    end
  endfunction

  // Maps a start mode to {autoneg, speed 100, full duplex, power-down}.
  function [3:0] mode_decode;
    input [2:0] mode;
    begin
      case (mode)
        `PCI_MODE_10_HALF: mode_decode = 4'h0;
        `PCI_MODE_10_FULL: mode_decode = 4'h2;
        `PCI_MODE_100_HALF: mode_decode = 4'h4;
        `PCI_MODE_100_FULL: mode_decode = 4'h6;
        `PCI_MODE_AN_100_HALF: mode_decode = 4'hC;
        `PCI_MODE_AN_ALL: mode_decode = 4'hE;
        default: mode_decode = 4'h1;
      endcase
    end
  endfunction

  // ========================================================================
  // Software-visible storage
  reg ctrl_soft_reset_n;
  reg ctrl_clk_sel;
  reg [2:0] ctrl_mode;
  reg [15:0] id_word1;
  reg [15:0] id_word2;
  reg [4:0] mgmt_addr;
  wire [15:0] ctrl_view;
  localparam [15:0] ctrl_standby_image = `PCI_CTRL_STANDBY;
  wire [15:0] status_view;
  wire [15:0] ctrl_merged;
  wire power_up_flag;

  // ========================================================================
  // Write channel state
  reg [4:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  wire wr_go;
  wire wr_hit;

  // ========================================================================
  // Read channel state
  reg [15:0] next_rd_value;

  // ========================================================================
  // Synchroniser for the analog power detect pin
  reg pwr_sync_a;
  reg pwr_sync_b;

  // Two flops before any logic looks at the detect pin.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_sync_a <= 1'b0;
      pwr_sync_b <= 1'b0;
    end else begin
      pwr_sync_a <= i_analog_power_detect;
      pwr_sync_b <= pwr_sync_a;
    end
  end

  // ========================================================================
  // Power-up reset flag
  pci_pwrup_timer #(
    .HOLD_CYCLES(PWRUP_CYCLES)
  ) u_pwrup_timer (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_power_detect(pwr_sync_b),
    .o_power_up_reset_flag(power_up_flag)
  );

  // ========================================================================
  // Register views

  // Fixed bits are produced here, so writes to them never stick.
  assign ctrl_view = {1'b1, ctrl_soft_reset_n, ctrl_clk_sel, 10'h000, ctrl_mode};

  // Only the power-up flag is live; the rest reads as zero.
  assign status_view = {power_up_flag, 15'h0000};

  // Control image with the pending write's byte lanes merged in.
  assign ctrl_merged = merge_lanes(ctrl_view, wr_data, wr_strb);

  // ========================================================================
  // Write address and data capture

  // A write commits once both channels are held and no response is pending.
  assign wr_go = ~o_s_axi_awready & ~o_s_axi_wready & ~o_s_axi_bvalid;
  assign wr_hit = addr_mapped(wr_addr);

  // Each channel is taken independently and released after the response.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      wr_addr <= 5'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        wr_addr <= {i_s_axi_awaddr[4:2], 2'h0};
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        wr_data <= i_s_axi_wdata;
        wr_strb <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Write response

  // Unmapped addresses are answered with a slave error and change nothing.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `PCI_RESP_OKAY;
    end else begin
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? `PCI_RESP_OKAY : `PCI_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Control register

  // Standby forces the standby image; otherwise a write updates fields.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_soft_reset_n <= 1'b1;
      ctrl_clk_sel <= 1'b0;
      ctrl_mode <= `PCI_MODE_RESET;
    end else if (i_standby) begin
      ctrl_soft_reset_n <= ctrl_standby_image[`PCI_CTRL_SOFT_RST_N];
      ctrl_clk_sel <= ctrl_standby_image[`PCI_CTRL_CLK_SEL];
      ctrl_mode <= ctrl_standby_image[`PCI_CTRL_MODE_MSB:0];
    end else if (wr_go && (wr_addr == `PCI_ADDR_MODE_CTRL)) begin
      ctrl_soft_reset_n <= ctrl_merged[`PCI_CTRL_SOFT_RST_N];
      ctrl_clk_sel <= ctrl_merged[`PCI_CTRL_CLK_SEL];
      ctrl_mode <= ctrl_merged[`PCI_CTRL_MODE_MSB:0];
    end
  end

  // ========================================================================
  // Identifier and address registers

  // All three clear to zero in standby and take writes otherwise.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      id_word1 <= `PCI_ID_RESET;
      id_word2 <= `PCI_ID_RESET;
      mgmt_addr <= `PCI_MADDR_RESET;
    end else if (i_standby) begin
      id_word1 <= `PCI_ID_RESET;
      id_word2 <= `PCI_ID_RESET;
      mgmt_addr <= `PCI_MADDR_RESET;
    end else if (wr_go) begin
      if (wr_addr == `PCI_ADDR_ID_WORD1) begin
        id_word1 <= merge_lanes(id_word1, wr_data, wr_strb);
      end
      if (wr_addr == `PCI_ADDR_ID_WORD2) begin
        id_word2 <= merge_lanes(id_word2, wr_data, wr_strb);
      end
      if (wr_addr == `PCI_ADDR_MGMT_ADDR) begin
        mgmt_addr <= wr_strb[0] ? wr_data[`PCI_ADDR_FIELD_MSB:0] : mgmt_addr;
      end
    end
  end

  // ========================================================================
  // Read data selection

  // Picks the addressed view; unmapped addresses read as zero.
  always @* begin
    next_rd_value = 16'h0000;
    case ({i_s_axi_araddr[4:2], 2'h0})
      `PCI_ADDR_MODE_CTRL: next_rd_value = ctrl_view;
      `PCI_ADDR_ID_WORD1: next_rd_value = id_word1;
      `PCI_ADDR_ID_WORD2: next_rd_value = id_word2;
      `PCI_ADDR_MGMT_ADDR: next_rd_value = {11'h000, mgmt_addr};
      `PCI_ADDR_PWR_STATUS: next_rd_value = status_view;
      default: next_rd_value = 16'h0000;
    endcase
  end

  // ========================================================================
  // Read channel

  // One read at a time; the answer comes one cycle after the address.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `PCI_RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= {16'h0000, next_rd_value};
        if (addr_mapped({i_s_axi_araddr[4:2], 2'h0})) begin
          o_s_axi_rresp <= `PCI_RESP_OKAY;
        end else begin
          o_s_axi_rresp <= `PCI_RESP_SLVERR;
        end
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // PHY reset output

  // The reset line follows the control bit one cycle later.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_phy_soft_reset_n <= 1'b1;
    end else begin
      o_phy_soft_reset_n <= ctrl_soft_reset_n;
    end
  end

  // ========================================================================
  // Applied strap values

  // Straps track the registers only while the PHY is held in reset, so the
  // value present at release is what the PHY keeps until the next reset.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_phy_clock_select <= 1'b0;
      o_phy_start_mode <= `PCI_MODE_RESET;
      o_id_word1_init <= `PCI_ID_RESET;
      o_id_word2_init <= `PCI_ID_RESET;
      o_mgmt_address_init <= `PCI_MADDR_RESET;
    end else if (!ctrl_soft_reset_n) begin
      o_phy_clock_select <= ctrl_clk_sel;
      o_phy_start_mode <= ctrl_mode;
      o_id_word1_init <= id_word1;
      o_id_word2_init <= id_word2;
      o_mgmt_address_init <= mgmt_addr;
    end
  end

  // ========================================================================
  // Decoded mode outputs

  // Decodes the applied mode into speed, duplex, negotiation and carrier use.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_phy_autoneg_enable <= 1'b0;
      o_phy_speed_100 <= 1'b0;
      o_phy_full_duplex <= 1'b0;
      o_phy_power_down <= 1'b1;
      o_phy_crs_on_transmit <= 1'b0;
    end else begin
      o_phy_crs_on_transmit <= mode_crs_tx(o_phy_start_mode);
      {o_phy_autoneg_enable, o_phy_speed_100, o_phy_full_duplex,
        o_phy_power_down} <= mode_decode(o_phy_start_mode);
    end
  end

endmodule // pci_phy_config_interface

// ---- verilog/pci_regs.vh ----
// Contract
// - Control writes except module reset reach the PHY only through a module reset.
// - Control bit 14 low holds the PHY in reset; high releases; starts high.
// - Control bit 13 picks PHY clock: 0 internal (default), 1 external clock.
// - Bit 15 reads 1, bits 12..3 read 0; software writes the same.
// - Bits 2..0 set PHY start mode; 110 power-down is the default.
// - 100 Mb/s half modes sense carrier on transmit and receive; full on receive.
// - Control resets to its initial state and is forced to C000 in standby.
// - First identifier register feeds PHY identifier word 1 at module reset.
// - Second identifier register feeds PHY identifier word 2 at module reset.
// - Identifier and address registers are zero at reset and in standby.
// - Address register bits 4..0 hold management address; bits 15..5 read zero.
// - Status bit 15 sets on analog power-up and clears after 21 ms.
// - Status is read-only, reset-initialised, bits 14..0 read zero.
// - After chip power-on reset the PHY enters power-down mode.
`ifndef PCI_REGS_VH
`define PCI_REGS_VH

// ==========================================================================
// Register byte addresses
`define PCI_ADDR_MODE_CTRL 5'h00
`define PCI_ADDR_ID_WORD1 5'h04
`define PCI_ADDR_ID_WORD2 5'h08
`define PCI_ADDR_MGMT_ADDR 5'h0C
`define PCI_ADDR_PWR_STATUS 5'h10

// ==========================================================================
// Field positions
`define PCI_CTRL_FIXED_ONE 15
`define PCI_CTRL_SOFT_RST_N 14
`define PCI_CTRL_CLK_SEL 13
`define PCI_CTRL_MODE_MSB 2
`define PCI_ADDR_FIELD_MSB 4
`define PCI_STAT_PWRUP 15

// ==========================================================================
// Reset values
`define PCI_CTRL_RESET 16'hC006
`define PCI_CTRL_STANDBY 16'hC000
`define PCI_MODE_RESET 3'h6
`define PCI_ID_RESET 16'h0000
`define PCI_MADDR_RESET 5'h00

// ==========================================================================
// Start mode encodings
`define PCI_MODE_10_HALF 3'h0
`define PCI_MODE_10_FULL 3'h1
`define PCI_MODE_100_HALF 3'h2
`define PCI_MODE_100_FULL 3'h3
`define PCI_MODE_AN_100_HALF 3'h4
`define PCI_MODE_POWER_DOWN 3'h6
`define PCI_MODE_AN_ALL 3'h7

// ==========================================================================
// AXI responses
`define PCI_RESP_OKAY 2'h0
`define PCI_RESP_SLVERR 2'h2

// ==========================================================================
// Timing
`define PCI_CLK_KHZ 40000
`define PCI_PWRUP_HOLD_MS 21
`define PCI_PWRUP_CYCLES (`PCI_PWRUP_HOLD_MS * `PCI_CLK_KHZ)

`endif

// ---- verilog/pci_pwrup_timer.v ----
`timescale 1ns/100ps
`include "pci_regs.vh"

module pci_pwrup_timer #(
  parameter HOLD_CYCLES = `PCI_PWRUP_CYCLES
) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_power_detect,
  output reg o_power_up_reset_flag
);

  // ========================================================================
  // Hold counter
  reg [19:0] hold_count;
  reg detect_seen;
  wire detect_rise;

  assign detect_rise = i_power_detect & ~detect_seen;

  // The flag starts set after power-on reset and sets again on each
  // detected supply rise; it clears itself once the hold time has run.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      detect_seen <= 1'b0;
      hold_count <= 20'h00000;
      o_power_up_reset_flag <= 1'b1;
    end else begin
      detect_seen <= i_power_detect;
      if (detect_rise) begin
        hold_count <= 20'h00000;
        o_power_up_reset_flag <= 1'b1;
      end else if (o_power_up_reset_flag) begin
        if (hold_count == HOLD_CYCLES[19:0] - 20'h00001) begin
          o_power_up_reset_flag <= 1'b0;
        end else begin
          hold_count <= hold_count + 20'h00001;
        end
      end
    end
  end

endmodule // pci_pwrup_timer

// ---- dv/pci_phy_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Behavioural PHY core that latches its straps when its module reset ends.
module pci_phy_model (
  input wire i_sys_clk,
  input wire i_phy_soft_reset_n,
  input wire i_phy_clock_select,
  input wire [2:0] i_phy_start_mode,
  input wire [15:0] i_id_word1_init,
  input wire [15:0] i_id_word2_init,
  input wire [4:0] i_mgmt_address_init,
  output reg [2:0] o_mode,
  output reg o_clk_sel,
  output reg [15:0] o_id1,
  output reg [15:0] o_id2,
  output reg [4:0] o_addr
);
  reg held;

  // The core wakes from power-on in power-down mode with internal clock.
  initial begin
    held = 1'b0;
    o_mode = 3'h6;
    o_clk_sel = 1'b0;
    o_id1 = 16'h0000;
    o_id2 = 16'h0000;
    o_addr = 5'h00;
  end

  // Straps are sampled only on the clock after reset is released.
  always @(posedge i_sys_clk) begin
    held <= !i_phy_soft_reset_n;
    if (held && i_phy_soft_reset_n) begin
      o_mode <= i_phy_start_mode;
      o_clk_sel <= i_phy_clock_select;
      o_id1 <= i_id_word1_init;
      o_id2 <= i_id_word2_init;
      o_addr <= i_mgmt_address_init;
    end
  end
endmodule // pci_phy_model

// ---- dv/pci_phy_config_checker.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Bus timing and strap checks seen from the top-level ports.
module pci_checker #(
  parameter PWRUP_CYCLES = 20
) (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire [4:0] i_s_axi_araddr,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire i_standby,
  input wire o_phy_soft_reset_n,
  input wire [2:0] o_phy_start_mode,
  input wire o_phy_autoneg_enable,
  input wire o_phy_speed_100,
  input wire o_phy_full_duplex,
  input wire o_phy_power_down,
  input wire o_phy_crs_on_transmit
);
  reg [4:0] rd_addr;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // Remembers the address of the read in flight.
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_addr <= 5'h00;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rd_addr <= i_s_axi_araddr;
    end
  end

  // ==========================================================================
  // Assertions.
  AST_RD_LAT: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("Read answer late.");
  AST_WR_LAT: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
    o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("Write answer late.");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("Write answer dropped.");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("Read answer dropped.");
  AST_CTRL_FIXED: assert property (o_s_axi_rvalid && rd_addr == 5'h00 |->
    o_s_axi_rdata[15] && o_s_axi_rdata[12:3] == 10'h000) else $error("Control bits.");
  AST_ADDR_ZERO: assert property (o_s_axi_rvalid && rd_addr == 5'h0C |->
    o_s_axi_rdata[15:5] == 11'h000) else $error("Address upper bits.");
  AST_STAT_ZERO: assert property (o_s_axi_rvalid && rd_addr == 5'h10 |->
    o_s_axi_rdata[14:0] == 15'h0000) else $error("Status low bits.");
  AST_STANDBY: assert property (i_standby |-> ##2 o_phy_soft_reset_n)
    else $error("Standby left PHY in reset.");
  AST_FREEZE: assert property (disable iff (!i_nrst || i_standby)
    o_phy_soft_reset_n && $past(o_phy_soft_reset_n) |-> $stable(o_phy_start_mode))
    else $error("Mode changed while running.");
  AST_PWRDN: assert property ($stable(o_phy_start_mode) |-> o_phy_power_down ==
    (o_phy_start_mode == 3'h6 || o_phy_start_mode == 3'h5)) else $error("Power-down.");
  AST_AUTONEG: assert property ($stable(o_phy_start_mode) |-> o_phy_autoneg_enable ==
    (o_phy_start_mode == 3'h4 || o_phy_start_mode == 3'h7)) else $error("Autoneg.");
  AST_CRS: assert property ($stable(o_phy_start_mode) && (o_phy_start_mode == 3'h2 ||
    o_phy_start_mode == 3'h3 || o_phy_start_mode == 3'h4) |->
    o_phy_crs_on_transmit == (o_phy_start_mode != 3'h3)) else $error("Carrier sense.");
  AST_SPEED_DUPLEX: assert property ($stable(o_phy_start_mode) |->
    o_phy_speed_100 == (o_phy_start_mode == 3'h2 || o_phy_start_mode == 3'h3 ||
    o_phy_start_mode == 3'h4 || o_phy_start_mode == 3'h7) && o_phy_full_duplex ==
    (o_phy_start_mode == 3'h1 || o_phy_start_mode == 3'h3 || o_phy_start_mode == 3'h7))
    else $error("Speed or duplex.");

  // Main scenarios.
  COV_WRITE: cover property (o_s_axi_bvalid && i_s_axi_bready);
  COV_STATUS: cover property (o_s_axi_rvalid && rd_addr == 5'h10);
  COV_RELEASE: cover property ($rose(o_phy_soft_reset_n));
endmodule // pci_checker

bind pci_phy_config_interface pci_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_pci_checker (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_s_axi_araddr(i_s_axi_araddr),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .i_standby(i_standby),
  .o_phy_soft_reset_n(o_phy_soft_reset_n), .o_phy_start_mode(o_phy_start_mode),
  .o_phy_autoneg_enable(o_phy_autoneg_enable), .o_phy_power_down(o_phy_power_down),
  .o_phy_speed_100(o_phy_speed_100), .o_phy_full_duplex(o_phy_full_duplex),
  .o_phy_crs_on_transmit(o_phy_crs_on_transmit));

// ---- dv/tb_pci_phy_config_interface.sv ----
`timescale 1ns/100ps
`include "pci_regs.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================================
// Register-level bench for the PHY configuration block.
module tb_pci_phy_config_interface;
  localparam HOLD = 4001; // Just over 100 us of PHY reset at 40 MHz.
  reg i_sys_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg [4:0] awaddr = 5'h00;
  reg [4:0] araddr = 5'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg standby = 1'b0, pwr_det = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, soft_n, clk_sel, m_clk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] mode, m_mode;
  wire [15:0] id1, id2, m_id1, m_id2;
  wire [4:0] maddr, m_addr;
  integer err_total = 0, compares = 0, i;
  reg [15:0] rd, v;
  reg [1:0] rs;
  reg [2:0] m, fz;
  reg [2:0] modes [0:6];

  pci_phy_config_interface #(.PWRUP_CYCLES(20)) dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'h3), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_standby(standby),
    .i_analog_power_detect(pwr_det), .o_phy_soft_reset_n(soft_n),
    .o_phy_clock_select(clk_sel), .o_phy_start_mode(mode), .o_id_word1_init(id1),
    .o_id_word2_init(id2), .o_mgmt_address_init(maddr), .o_phy_autoneg_enable(),
    .o_phy_speed_100(), .o_phy_full_duplex(), .o_phy_power_down(),
    .o_phy_crs_on_transmit());

  pci_phy_model u_phy (
    .i_sys_clk(i_sys_clk), .i_phy_soft_reset_n(soft_n), .i_phy_clock_select(clk_sel),
    .i_phy_start_mode(mode), .i_id_word1_init(id1), .i_id_word2_init(id2),
    .i_mgmt_address_init(maddr), .o_mode(m_mode), .o_clk_sel(m_clk), .o_id1(m_id1),
    .o_id2(m_id2), .o_addr(m_addr));

  // Free-running system clock.
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Prints the verdict and ends the run.
  task stop_test;
    begin
      if (err_total == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // One write: address and data offered together, each released when taken.
  task automatic wr(input [4:0] a, input [15:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      @(posedge i_sys_clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge i_sys_clk);
        n = n + 1;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready) && n < 100);
      r = bresp;
      bready <= 1'b0;
      if (n >= 100) err_total++;
    end
  endtask

  // One read: address released when taken, answer sampled on the handshake.
  task automatic rd_reg(input [4:0] a, output [15:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      @(posedge i_sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge i_sys_clk);
        n = n + 1;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && n < 100);
      d = rdata[15:0];
      r = rresp;
      rready <= 1'b0;
      if (n >= 100) err_total++;
    end
  endtask

  // Reads a register and compares data and response.
  task automatic rc(input [4:0] a, input [15:0] e, input [1:0] er);
    begin
      rd_reg(a, rd, rs);
      `CHK(rd, e)
      `CHK(rs, er)
    end
  endtask

  // Cuts a hung run short.
  initial begin
    #(25 * 80000);
    err_total++;
    stop_test;
  end

  // Main sequence.
  initial begin
    modes[0] = 3'h0; modes[1] = 3'h1; modes[2] = 3'h2; modes[3] = 3'h3;
    modes[4] = 3'h4; modes[5] = 3'h6; modes[6] = 3'h7;
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rc(`PCI_ADDR_PWR_STATUS, 16'h8000, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_MODE_CTRL, 16'hC006, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_ID_WORD1, 16'h0000, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_ID_WORD2, 16'h0000, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_MGMT_ADDR, 16'h0000, `PCI_RESP_OKAY);
    `CHK(mode, 3'h6)
    `CHK(soft_n, 1'b1)
    i = 0;
    do begin
      rd_reg(`PCI_ADDR_PWR_STATUS, rd, rs);
      i++;
    end while (rd[15] && i < 40);
    `CHK(rd, 16'h0000)
    wr(`PCI_ADDR_ID_WORD1, 16'hA5C3, rs);
    wr(`PCI_ADDR_ID_WORD2, 16'h3C5A, rs);
    wr(`PCI_ADDR_MGMT_ADDR, 16'hFFFF, rs);
    wr(`PCI_ADDR_PWR_STATUS, 16'hFFFF, rs);
    rc(`PCI_ADDR_ID_WORD1, 16'hA5C3, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_ID_WORD2, 16'h3C5A, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_MGMT_ADDR, 16'h001F, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_PWR_STATUS, 16'h0000, `PCI_RESP_OKAY);
    `CHK(id1, 16'h0000)
    wr(5'h14, 16'h1234, rs);
    `CHK(rs, `PCI_RESP_SLVERR)
    rc(5'h14, 16'h0000, `PCI_RESP_SLVERR);
    wr(`PCI_ADDR_MODE_CTRL, 16'h5FFE, rs);
    rc(`PCI_ADDR_MODE_CTRL, 16'hC006, `PCI_RESP_OKAY);
    for (i = 0; i < 7; i = i + 1) begin
      m = modes[i];
      v = {2'b00, i[0], 10'h000, m};
      fz = (m == 3'h0) ? 3'h3 : 3'h0;
      wr(`PCI_ADDR_MODE_CTRL, v, rs);
      rc(`PCI_ADDR_MODE_CTRL, v | 16'h8000, `PCI_RESP_OKAY);
      `CHK(soft_n, 1'b0)
      `CHK(mode, m)
      `CHK(clk_sel, i[0])
      `CHK(id2, 16'h3C5A)
      repeat (HOLD) @(posedge i_sys_clk);
      wr(`PCI_ADDR_MODE_CTRL, v | 16'hC000, rs);
      wr(`PCI_ADDR_MODE_CTRL, {13'h1800, fz}, rs);
      `CHK(soft_n, 1'b1)
      `CHK(mode, m)
      `CHK(clk_sel, i[0])
      `CHK(m_mode, m)
      `CHK(m_clk, i[0])
      `CHK(m_id1, 16'hA5C3)
      `CHK(m_addr, 5'h1F)
    end
    wr(`PCI_ADDR_MODE_CTRL, 16'h0003, rs);
    @(posedge i_sys_clk);
    standby <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    standby <= 1'b0;
    rc(`PCI_ADDR_MODE_CTRL, 16'hC000, `PCI_RESP_OKAY);
    `CHK(soft_n, 1'b1)
    rc(`PCI_ADDR_ID_WORD1, 16'h0000, `PCI_RESP_OKAY);
    rc(`PCI_ADDR_MGMT_ADDR, 16'h0000, `PCI_RESP_OKAY);
    @(posedge i_sys_clk);
    pwr_det <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    rc(`PCI_ADDR_PWR_STATUS, 16'h8000, `PCI_RESP_OKAY);
    repeat (25) @(posedge i_sys_clk);
    rc(`PCI_ADDR_PWR_STATUS, 16'h0000, `PCI_RESP_OKAY);
    stop_test;
  end
endmodule // tb_pci_phy_config_interface
